/* File: shared/sar_ctl_cfg.svh */
// Constants for the converter control block
`ifndef SAR_CTL_CFG_SVH
`define SAR_CTL_CFG_SVH
`define RES_BITS 12
`define SHORT_BITS 8
`define CSR_CTRL 4'h0
`define CSR_STATUS 4'h4
`define CSR_RESULT 4'h8
`define CSR_COMPARE 4'hC
`define CTRL_CE_BIT 0
`define CTRL_CSN_BIT 1
`define CTRL_RC_BIT 2
`define CTRL_BYTE_SEL_BIT 3
`define CTRL_W12_BIT 4
`define CTRL_STANDALONE_BIT 5
`define CTRL_RESET 6'h02
`endif

/* File: shared/sar_ctl_pkg.sv */
// Types shared by the converter control modules
package sar_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TRIAL = 3'b010,
    ST_DONE = 3'b100
  } conv_state_e;
endpackage

/* File: shared/sar_ctl_if.sv */
// Signals between control section and approximation register
interface sar_ctl_if;
  logic start;
  logic shortCycle;
  logic clkEnable;
  logic endOfConv;
  logic [11:0] code;
  modport ctl (output start, output shortCycle, input clkEnable,
    input endOfConv, input code);
  modport sar (input start, input shortCycle, output clkEnable,
    output endOfConv, output code);
endinterface

/* File: logic/sar_register.sv */
// Successive-approximation register with MSB-first trials
`include "sar_ctl_cfg.svh"
module sar_register
  import sar_ctl_pkg::*;
#(
  parameter int Bits = `RES_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic compLess,
  output logic [3:0] trialIdx,
  sar_ctl_if.sar bus
);
  initial begin
    if (Bits != 12) $error("sar_register serves 12 bits only");
  end

  logic [11:0] code_ff;
  logic [3:0] bitIdx_ff;
  logic [3:0] lastIdx_ff;
  logic run_ff;
  logic eoc_ff;

  assign bus.code = code_ff;
  assign bus.clkEnable = run_ff;
  assign bus.endOfConv = eoc_ff;
  assign trialIdx = bitIdx_ff;

  // RULE14: clear and enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff <= 1'b0;
      eoc_ff <= 1'b0;
      bitIdx_ff <= 4'hB;
      lastIdx_ff <= 4'h0;
    end else begin
      eoc_ff <= 1'b0;
      if (bus.start && !run_ff) begin
        run_ff <= 1'b1;
        bitIdx_ff <= 4'hB;
        // RULE20: eight or twelve trials
        lastIdx_ff <= bus.shortCycle ? 4'h4 : 4'h0;
      end else if (run_ff) begin
        if (bitIdx_ff == lastIdx_ff) begin
          run_ff <= 1'b0;
          eoc_ff <= 1'b1;
        end else begin
          bitIdx_ff <= bitIdx_ff - 4'h1;
        end
      end
    end
  end

  // RULE17: keep bit if below
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_ff <= 12'h000;
    end else if (bus.start && !run_ff) begin
      code_ff <= 12'h000;
    end else if (run_ff) begin
      code_ff[bitIdx_ff] <= compLess;
    end
  end
endmodule

/* File: logic/sar_adc_control_interface.sv */
// Converter control section, output buffers and Avalon register slave
// Contract
// RULE1: Byte select low at start runs full twelve-bit cycle.
// RULE2: Byte select high at start runs short eight-bit cycle.
// RULE3: Byte read with byte select low drives eight MSBs.
// RULE4: Byte read, byte select high: low nibble, middle lines zero.
// RULE5: Activate is active high; commands act only while asserted.
// RULE6: Select is active low; high means deselected.
// RULE7: Upper lines carry bits 11-8; off for low byte.
// RULE8: Middle lines carry bits 7-4 in word or MSB byte.
// RULE9: Lower lines carry bits 3-0 when byte select high, else off; code also drives them in word mode with byte select low.
// RULE10: Full control: read/convert high reads, low converts.
// RULE11: Standalone: each falling read/convert edge starts conversion.
// RULE12: Busy output high whole conversion, low after.
// RULE13: Width select low gives two bytes, high one word.
// RULE14: Convert command enables clock and clears register.
// RULE15: Running conversion ignores restarts and withholds data.
// RULE16: End flag stops clock, drops busy, allows reads.
// RULE17: Trials MSB to LSB, keep bit when DAC below input.
// RULE18: Decision only while activate high and select low.
// RULE19: Data lines released whenever no read is enabled.
// RULE20: Short ends after eight trials, full after twelve.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`include "sar_ctl_cfg.svh"
module sar_adc_control_interface
  import sar_ctl_pkg::*;
#(
  parameter int Bits = `RES_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic compLessPin,
  output logic [11:0] dataOut,
  output logic [11:0] dataOe,
  output logic convInProgress
);
  initial begin
    if (Bits != 12) $error("Only twelve-bit resolution is served");
  end

  sar_ctl_if link();
  logic [3:0] trialIdx;
  logic compMeta_ff;
  logic compSync_ff;
  logic [5:0] ctrl_ff;
  logic [11:0] compare_ff;
  logic compSrcSw_ff;
  logic start_ff;
  logic shortCycle_ff;
  logic rcPrev_ff;
  logic busy_ff;
  logic waitReq_ff;
  logic ack;
  logic [31:0] readData_ff;
  logic [11:0] result_ff;
  logic [11:0] dataOut_ff;
  logic [11:0] dataOe_ff;
  logic [11:0] nxt_dataOut;
  logic [11:0] nxt_dataOe;
  conv_state_e state_ff;
  logic chipOn;
  logic readCmd;
  logic convCmd;
  logic compLess;

  function automatic logic [11:0] trialValue(input logic [11:0] code,
                                             input logic [3:0] idx);
    logic [11:0] v;
    v = code;
    v[idx] = 1'b1;
    return v;
  endfunction

  // Comparator pin comes from the analog side, so synchronise it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compMeta_ff <= 1'b0;
      compSync_ff <= 1'b0;
    end else begin
      compMeta_ff <= compLessPin;
      compSync_ff <= compMeta_ff;
    end
  end

  // Software compare value stands in for the analog input when selected
  assign compLess = compSrcSw_ff ?
    (trialValue(link.code, trialIdx) <= compare_ff) : compSync_ff;

  // RULE5: activate high
  // RULE6: select low
  // RULE18: both together
  assign chipOn = ctrl_ff[`CTRL_CE_BIT] && !ctrl_ff[`CTRL_CSN_BIT];
  // RULE10: level decides
  assign readCmd = chipOn && ctrl_ff[`CTRL_RC_BIT] &&
    !ctrl_ff[`CTRL_STANDALONE_BIT];
  assign convCmd = ctrl_ff[`CTRL_STANDALONE_BIT] ?
    // RULE11: falling edge starts
    (rcPrev_ff && !ctrl_ff[`CTRL_RC_BIT] && chipOn) :
    (chipOn && !ctrl_ff[`CTRL_RC_BIT]);

  sar_register #(.Bits(Bits)) u_sar (
    .clk(clk),
    .rst(rst),
    .compLess(compLess),
    .trialIdx(trialIdx),
    .bus(link)
  );
  assign link.start = start_ff;
  assign link.shortCycle = shortCycle_ff;

  // Avalon slave: one wait cycle, so read data is settled when released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= !((avs_read || avs_write) && waitReq_ff);
    end
  end
  assign ack = !waitReq_ff;
  assign avs_waitrequest = waitReq_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET;
      compare_ff <= 12'h000;
      compSrcSw_ff <= 1'b0;
    end else if (avs_write && ack) begin
      case (avs_address)
        `CSR_CTRL: ctrl_ff <= avs_writedata[5:0];
        `CSR_COMPARE: begin
          compare_ff <= avs_writedata[11:0];
          compSrcSw_ff <= avs_writedata[31];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData_ff <= 32'h0000_0000;
    end else if (avs_read && waitReq_ff) begin
      case (avs_address)
        `CSR_CTRL: readData_ff <= {26'h0, ctrl_ff};
        `CSR_STATUS: readData_ff <= {29'h0, state_ff};
        // RULE15: data withheld while busy
        `CSR_RESULT: readData_ff <= busy_ff ? 32'h0 : {20'h0, result_ff};
        `CSR_COMPARE: readData_ff <= {compSrcSw_ff, 19'h0, compare_ff};
        default: readData_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = readData_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rcPrev_ff <= 1'b0;
    end else begin
      rcPrev_ff <= ctrl_ff[`CTRL_RC_BIT];
    end
  end

  // Conversion sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      start_ff <= 1'b0;
      shortCycle_ff <= 1'b0;
      busy_ff <= 1'b0;
      result_ff <= 12'h000;
    end else begin
      start_ff <= 1'b0;
      case (state_ff)
        ST_IDLE, ST_DONE: begin
          if (convCmd) begin
            // RULE14: start clears register
            // RULE1: select low full
            // RULE2: select high short
            start_ff <= 1'b1;
            shortCycle_ff <= ctrl_ff[`CTRL_BYTE_SEL_BIT];
            busy_ff <= 1'b1;
            state_ff <= ST_TRIAL;
          end
        end
        ST_TRIAL: begin
          // RULE15: no restart while running
          // RULE16: end flag finishes
          // RULE12: busy until done
          if (link.endOfConv) begin
            busy_ff <= 1'b0;
            result_ff <= link.code;
            state_ff <= ST_DONE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Output buffer steering
  always_comb begin
    nxt_dataOut = 12'h000;
    nxt_dataOe = 12'h000;
    // RULE19: released unless reading
    if (readCmd && !busy_ff) begin
      // RULE13: width select
      if (ctrl_ff[`CTRL_W12_BIT]) begin
        // RULE7: upper nibble word
        // RULE8: middle nibble word
        nxt_dataOut = result_ff;
        nxt_dataOe = 12'hFFF;
      end else if (!ctrl_ff[`CTRL_BYTE_SEL_BIT]) begin
        // RULE3: eight MSBs
        nxt_dataOut = {result_ff[11:4], 4'h0};
        nxt_dataOe = 12'hFF0;
      end else begin
        // RULE4: low nibble, zeros
        // RULE9: lower nibble on
        nxt_dataOut = {8'h00, result_ff[3:0]};
        nxt_dataOe = 12'h0FF;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataOut_ff <= 12'h000;
      dataOe_ff <= 12'h000;
    end else begin
      dataOut_ff <= nxt_dataOut;
      dataOe_ff <= nxt_dataOe;
    end
  end
  assign dataOut = dataOut_ff;
  assign dataOe = dataOe_ff;
  assign convInProgress = busy_ff;
endmodule

/* File: tb/sar_adc_control_interface_assertions.sv */
// Output checks for the converter control block
module sar_adc_control_interface_assertions #(
  parameter int Bits = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] dataOut,
  input wire logic [11:0] dataOe,
  input wire logic convInProgress
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence busyRise;
    $rose(convInProgress);
  endsequence
  a_busy_min:
    assert property (busyRise |-> convInProgress [*8])
    else $error("busy shorter than eight trials");
  a_busy_max:
    assert property (busyRise |-> ##[8:30] !convInProgress)
    else $error("conversion did not end");
  a_off_busy:
    assert property (convInProgress && $past(convInProgress) |-> !dataOe)
    else $error("lines driven during conversion");
  a_lsb_zero:
    assert property (dataOe == 12'h0FF |-> dataOut[7:4] == 4'h0)
    else $error("low byte middle lines not zero");
  a_msb_byte:
    assert property (dataOe[7:0] == 8'hF0 |-> dataOe[11:8] == 4'hF)
    else $error("high byte not fully driven");
  a_upper_grp:
    assert property (dataOe[11:8] != 4'h0 |-> dataOe[11:4] == 8'hFF)
    else $error("upper lines split");
  a_lower_grp:
    assert property (dataOe[3:0] != 4'h0 |-> dataOe[7:0] == 8'hFF)
    else $error("lower lines split");
  a_middle_grp:
    assert property (dataOe[7:4] != 4'h0 |-> dataOe[7:4] == 4'hF)
    else $error("middle lines split");
endmodule
bind sar_adc_control_interface sar_adc_control_interface_assertions
  #(.Bits(Bits)) i_checker (.clk, .rst, .dataOut, .dataOe, .convInProgress);

/* File: tb/bus_host_model.sv */
// Avalon host model issuing register transfers
module bus_host_model (
  input wire logic clk,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  task automatic access(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

/* File: tb/tb_sar_adc_control_interface.sv */
// Self-checking bench for the converter control block
`include "sar_ctl_cfg.svh"
module tb_sar_adc_control_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, avs_read, avs_write, avs_waitrequest;
  logic compLessPin, convInProgress;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [11:0] dataOut, dataOe;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  sar_adc_control_interface i_sar_adc_control_interface (.clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .compLessPin, .dataOut, .dataOe, .convInProgress);
  bus_host_model host (.clk, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    host.access(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic conv(input logic [31:0] cmd, input logic [31:0] follow);
    wr(`CSR_CTRL, cmd);
    wr(`CSR_CTRL, follow);
    repeat (2) @(posedge clk);
    check({31'h0, convInProgress}, 32'h1);
    rd(`CSR_RESULT, 32'h0);
    while (convInProgress !== 1'b0) @(posedge clk);
    $display("conversion %h done at %0t", cmd, $time);
  endtask
  task automatic lines(input logic [31:0] cmd, input logic [11:0] oe,
    input logic [11:0] val);
    wr(`CSR_CTRL, cmd);
    repeat (2) @(posedge clk);
    check({20'h0, dataOe}, {20'h0, oe});
    check({20'h0, dataOut & oe}, {20'h0, val});
    $display("read mode %h done at %0t", cmd, $time);
  endtask
  initial begin
    rst = 1'b1;
    compLessPin = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`CSR_CTRL, 32'h2);
    rd(`CSR_STATUS, 32'h1);
    rd(4'h2, 32'h0);
    // Software compare makes the code equal the compare value
    wr(`CSR_COMPARE, 32'h8000_0A5C);
    conv(32'h01, 32'h15);
    rd(`CSR_RESULT, 32'hA5C);
    lines(32'h15, 12'hFFF, 12'hA5C);
    lines(32'h05, 12'hFF0, 12'hA50);
    lines(32'h0D, 12'h0FF, 12'h00C);
    lines(32'h07, 12'h000, 12'h000);
    lines(32'h14, 12'h000, 12'h000);
    conv(32'h09, 32'h0D);
    rd(`CSR_RESULT, 32'hA50);
    wr(`CSR_COMPARE, 32'h0);
    compLessPin <= 1'b1;
    conv(32'h25, 32'h21);
    rd(`CSR_RESULT, 32'hFFF);
    complete_run();
  end
endmodule
